// ### rtl/ascii_serial_framer.sv
// Notes on behaviour
// - Zero start character: none expected nor sent
// - Received start character opens a new frame
// - Nonzero start character sent before payload
// - First end character ends and trails frames
// - Second end character ends and trails frames
// - Nonzero length limit completes frame at count
// - Nonzero timeout completes frame after silence
// - Earliest true termination ends the frame
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ascii_serial_framer
   import framer_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic      [31:0] RDATA,
   output logic             IRQ,
   input  wire logic        RXC_VALID,
   input  wire logic [7:0]  RXC_DATA,
   output logic             RXF_VALID,
   output logic      [7:0]  RXF_DATA,
   output logic             RXF_FIRST,
   output logic             RXF_LAST,
   input  wire logic        TXP_VALID,
   input  wire logic [7:0]  TXP_DATA,
   input  wire logic        TXP_LAST,
   output logic             TXP_READY,
   output logic             TXC_VALID,
   output logic      [7:0]  TXC_DATA,
   input  wire logic        TXC_READY
);
   // ==========================================================
   // Register file
   // ==========================================================
   cfg_type                cfg_ff;
   logic [IRQ_WIDTH-1:0]   stat_ff;
   logic [IRQ_WIDTH-1:0]   mask_ff;
   logic [31:0]            rdata_ff;
   logic                   irq_ff;
   end_cause_type          cause_ff;
   logic [15:0]            last_cnt_ff;

   function automatic logic hit_chr(input logic [7:0] c, input logic [7:0] d);
      hit_chr = (c != 8'h00) && (c == d);
   endfunction

   wire wr_start = WR && (ADDR == ADDR_START);
   wire wr_end1  = WR && (ADDR == ADDR_END1);
   wire wr_end2  = WR && (ADDR == ADDR_END2);
   wire wr_len   = WR && (ADDR == ADDR_LEN);
   wire wr_tmo   = WR && (ADDR == ADDR_TIMEOUT);
   wire wr_stat  = WR && (ADDR == ADDR_IRQ_STAT);
   wire wr_mask  = WR && (ADDR == ADDR_IRQ_MASK);

   logic [31:0] rd_mux;
   always_comb
   begin
      if (ADDR == ADDR_START)
         rd_mux = {24'h00_0000, cfg_ff.start_chr};
      else if (ADDR == ADDR_END1)
         rd_mux = {24'h00_0000, cfg_ff.end1_chr};
      else if (ADDR == ADDR_END2)
         rd_mux = {24'h00_0000, cfg_ff.end2_chr};
      else if (ADDR == ADDR_LEN)
         rd_mux = {16'h0000, cfg_ff.len_limit};
      else if (ADDR == ADDR_TIMEOUT)
         rd_mux = {16'h0000, cfg_ff.timeout_ms};
      else if (ADDR == ADDR_IRQ_STAT)
         rd_mux = {29'h0000_0000, stat_ff};
      else if (ADDR == ADDR_IRQ_MASK)
         rd_mux = {29'h0000_0000, mask_ff};
      else if (ADDR == ADDR_RX_STAT)
         rd_mux = {29'h0000_0000, cause_ff};
      else if (ADDR == ADDR_RX_COUNT)
         rd_mux = {16'h0000, last_cnt_ff};
      else
         rd_mux = 32'h0000_0000;
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         cfg_ff   <= '{RST_CHAR, RST_CHAR, RST_CHAR, RST_LEN, RST_TIMEOUT};
         mask_ff  <= '0;
         rdata_ff <= 32'h0000_0000;
      end
      else
      begin
         if (wr_start)
            cfg_ff.start_chr <= WDATA[7:0];
         if (wr_end1)
            cfg_ff.end1_chr <= WDATA[7:0];
         if (wr_end2)
            cfg_ff.end2_chr <= WDATA[7:0];
         if (wr_len)
            cfg_ff.len_limit <= WDATA[15:0];
         if (wr_tmo)
            cfg_ff.timeout_ms <= WDATA[15:0];
         if (wr_mask)
            mask_ff <= WDATA[IRQ_WIDTH-1:0];
         rdata_ff <= RD ? rd_mux : 32'h0000_0000;
      end
   end

   // ==========================================================
   // Receive framing
   // ==========================================================
   logic        in_frame_ff;
   logic [15:0] cnt_ff;
   char_type    rxq_ff;
   logic        rxf_first_ff;
   logic        rxf_last_ff;
   logic        tmo_hit;

   wire         need_start = (cfg_ff.start_chr != 8'h00);
   wire         is_start   = RXC_VALID && hit_chr(cfg_ff.start_chr, RXC_DATA);
   wire         is_end1    = hit_chr(cfg_ff.end1_chr, RXC_DATA);
   wire         is_end2    = hit_chr(cfg_ff.end2_chr, RXC_DATA);
   wire [15:0]  cnt_inc    = cnt_ff + 16'h0001;
   wire         len_hit    = (cfg_ff.len_limit != 16'h0000) && (cnt_inc >= cfg_ff.len_limit);
   // Without a start character any byte opens a frame
   wire         open_ok    = in_frame_ff || !need_start;
   wire         take       = RXC_VALID && !is_start && open_ok;
   wire         chr_end    = take && (is_end1 || is_end2 || len_hit);
   // Timeout only closes an open frame, even one with no data after its start character
   wire         tmo_end    = tmo_hit && in_frame_ff && !RXC_VALID;

   end_cause_type nxt_cause;
   always_comb
   begin
      // Earliest condition wins; same-byte ties take delimiter first
      if (take && is_end1)
         nxt_cause = END_CHR1;
      else if (take && is_end2)
         nxt_cause = END_CHR2;
      else if (take && len_hit)
         nxt_cause = END_LEN;
      else if (tmo_end)
         nxt_cause = END_TIME;
      else
         nxt_cause = cause_ff;
   end

   silence_timer #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_timer (
      .clk      (SYS_CLK),
      .rst      (RST),
      .restart  (RXC_VALID),
      .arm      (in_frame_ff),
      .limit_ms (cfg_ff.timeout_ms),
      .expired  (tmo_hit)
   );

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         in_frame_ff  <= 1'b0;
         cnt_ff       <= 16'h0000;
         rxq_ff       <= '0;
         rxf_first_ff <= 1'b0;
         rxf_last_ff  <= 1'b0;
         cause_ff     <= END_NONE;
         last_cnt_ff  <= 16'h0000;
      end
      else
      begin
         rxq_ff.valid <= take;
         rxq_ff.data  <= RXC_DATA;
         rxf_first_ff <= take && (cnt_ff == 16'h0000);
         rxf_last_ff  <= chr_end;
         cause_ff     <= nxt_cause;
         if (is_start)
         begin
            in_frame_ff <= 1'b1;
            cnt_ff      <= 16'h0000;
         end
         else if (chr_end || tmo_end)
         begin
            in_frame_ff <= 1'b0;
            cnt_ff      <= 16'h0000;
            last_cnt_ff <= chr_end ? cnt_inc : cnt_ff;
         end
         else if (take)
         begin
            in_frame_ff <= 1'b1;
            cnt_ff      <= cnt_inc;
         end
      end
   end

   // ==========================================================
   // Transmit framing
   // ==========================================================
   typedef enum logic [2:0]
   {
      TX_IDLE  = 3'b000,
      TX_START = 3'b001,
      TX_DATA  = 3'b010,
      TX_END1  = 3'b011,
      TX_END2  = 3'b100
   } tx_state_type;

   tx_state_type tx_ff;
   tx_state_type nxt_tx;
   char_type     txc_ff;
   logic         txp_ready_ff;
   logic         tx_done_ff;

   // Output slot is free when empty or being drained this cycle
   wire slot_free  = !txc_ff.valid || TXC_READY;
   wire has_end1   = (cfg_ff.end1_chr != 8'h00);
   wire has_end2   = (cfg_ff.end2_chr != 8'h00);
   wire pay_take   = (tx_ff == TX_DATA) && slot_free && TXP_VALID && txp_ready_ff;
   tx_state_type after_pay;
   assign after_pay = has_end1 ? TX_END1 : (has_end2 ? TX_END2 : TX_IDLE);

   char_type nxt_txc;
   always_comb
   begin
      nxt_tx  = tx_ff;
      nxt_txc = slot_free ? '0 : txc_ff;
      case (tx_ff)
         TX_IDLE:
            if (TXP_VALID)
               nxt_tx = need_start ? TX_START : TX_DATA;
         TX_START:
            if (slot_free)
            begin
               nxt_txc = '{1'b1, cfg_ff.start_chr};
               nxt_tx  = TX_DATA;
            end
         TX_DATA:
            if (pay_take)
            begin
               nxt_txc = '{1'b1, TXP_DATA};
               if (TXP_LAST)
                  nxt_tx = after_pay;
            end
         TX_END1:
            if (slot_free)
            begin
               nxt_txc = '{1'b1, cfg_ff.end1_chr};
               nxt_tx  = has_end2 ? TX_END2 : TX_IDLE;
            end
         TX_END2:
            if (slot_free)
            begin
               nxt_txc = '{1'b1, cfg_ff.end2_chr};
               nxt_tx  = TX_IDLE;
            end
         default:
            nxt_tx = TX_IDLE;
      endcase
   end

   wire tx_fin = (tx_ff != TX_IDLE) && (nxt_tx == TX_IDLE);

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         tx_ff        <= TX_IDLE;
         txc_ff       <= '0;
         txp_ready_ff <= 1'b0;
         tx_done_ff   <= 1'b0;
      end
      else
      begin
         tx_ff        <= nxt_tx;
         txc_ff       <= nxt_txc;
         // One-cycle ready, raised only over an empty slot, so no handshake is refused
         txp_ready_ff <= (nxt_tx == TX_DATA) && !txp_ready_ff && !nxt_txc.valid;
         tx_done_ff   <= tx_fin;
      end
   end

   // ==========================================================
   // Interrupts: set wins over write-one-to-clear
   // ==========================================================
   logic [IRQ_WIDTH-1:0] ev;
   always_comb
   begin
      ev               = '0;
      ev[IRQ_RX_DONE]  = chr_end || tmo_end;
      ev[IRQ_TX_DONE]  = tx_done_ff;
      ev[IRQ_RX_START] = is_start;
   end

   wire [IRQ_WIDTH-1:0] clr = wr_stat ? WDATA[IRQ_WIDTH-1:0] : '0;
   wire [IRQ_WIDTH-1:0] nxt_stat = (stat_ff & ~clr) | ev;

   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
      begin
         stat_ff <= '0;
         irq_ff  <= 1'b0;
      end
      else
      begin
         stat_ff <= nxt_stat;
         irq_ff  <= |(nxt_stat & mask_ff);
      end
   end

   assign RDATA     = rdata_ff;
   assign IRQ       = irq_ff;
   assign RXF_VALID = rxq_ff.valid;
   assign RXF_DATA  = rxq_ff.data;
   assign RXF_FIRST = rxf_first_ff;
   assign RXF_LAST  = rxf_last_ff;
   assign TXP_READY = txp_ready_ff;
   assign TXC_VALID = txc_ff.valid;
   assign TXC_DATA  = txc_ff.data;
endmodule

// ### rtl/framer_pkg.sv
package framer_pkg;
   // ==========================================================
   // Register map (word offsets are byte addresses)
   // ==========================================================
   localparam logic [7:0] ADDR_START     = 8'h00;
   localparam logic [7:0] ADDR_END1      = 8'h04;
   localparam logic [7:0] ADDR_END2      = 8'h08;
   localparam logic [7:0] ADDR_LEN       = 8'h0C;
   localparam logic [7:0] ADDR_TIMEOUT   = 8'h10;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h14;
   localparam logic [7:0] ADDR_IRQ_MASK  = 8'h18;
   localparam logic [7:0] ADDR_RX_STAT   = 8'h1C;
   localparam logic [7:0] ADDR_RX_COUNT  = 8'h20;

   // ==========================================================
   // Interrupt status bits
   // ==========================================================
   localparam int IRQ_RX_DONE  = 0;
   localparam int IRQ_TX_DONE  = 1;
   localparam int IRQ_RX_START = 2;
   localparam int IRQ_WIDTH    = 3;

   // ==========================================================
   // Reset values and timing
   // ==========================================================
   localparam logic [7:0]  RST_CHAR    = 8'h00;
   localparam logic [15:0] RST_LEN     = 16'h0000;
   localparam logic [15:0] RST_TIMEOUT = 16'h0000;
   localparam int          CLK_HZ      = 20_000_000;
   localparam int          MS_PER_S    = 1000;
   localparam int          CYC_PER_MS  = CLK_HZ / MS_PER_S;

   // Frame end cause codes
   typedef enum logic [2:0]
   {
      END_NONE = 3'b000,
      END_CHR1 = 3'b001,
      END_CHR2 = 3'b010,
      END_LEN  = 3'b011,
      END_TIME = 3'b100
   } end_cause_type;

   typedef struct packed
   {
      logic       valid;
      logic [7:0] data;
   } char_type;

   typedef struct packed
   {
      logic [7:0]  start_chr;
      logic [7:0]  end1_chr;
      logic [7:0]  end2_chr;
      logic [15:0] len_limit;
      logic [15:0] timeout_ms;
   } cfg_type;
endpackage

// ### rtl/silence_timer.sv
`timescale 1ns/1ps
module silence_timer
   import framer_pkg::*;
#(
   parameter int CYCLES_PER_MS = CYC_PER_MS
)
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        restart,
   input  wire logic        arm,
   input  wire logic [15:0] limit_ms,
   output logic             expired
);
   // ==========================================================
   // Millisecond prescaler and count of quiet milliseconds
   // ==========================================================
   logic [31:0] pre_ff;
   logic [15:0] ms_ff;
   logic        exp_ff;
   wire         tick    = (pre_ff == 32'(CYCLES_PER_MS - 1));
   wire         running = arm && (limit_ms != 16'h0000) && !exp_ff;
   wire         hit     = running && tick && (ms_ff + 16'h0001 >= limit_ms);

   always_ff @(posedge clk)
   begin
      if (rst || restart || !running)
      begin
         pre_ff <= 32'h0000_0000;
         ms_ff  <= 16'h0000;
      end
      else if (tick)
      begin
         pre_ff <= 32'h0000_0000;
         ms_ff  <= ms_ff + 16'h0001;
      end
      else
         pre_ff <= pre_ff + 32'h0000_0001;
   end

   always_ff @(posedge clk)
   begin
      if (rst || restart || !arm)
         exp_ff <= 1'b0;
      else if (hit)
         exp_ff <= 1'b1;
   end

   assign expired = hit;
endmodule

// ### tb/char_link_model.sv
`timescale 1ns/1ps
module char_link_model
(
   input  wire logic       clk,
   output logic            rxc_valid,
   output logic      [7:0] rxc_data,
   input  wire logic       txc_valid,
   input  wire logic [7:0] txc_data,
   output logic            txc_ready
);
   integer     seed = 32'h5a5a_0001;
   logic [7:0] seen[$];
   initial
   begin
      rxc_valid = 1'b0;
      rxc_data  = 8'h00;
      txc_ready = 1'b0;
   end
   // Random stalls keep outgoing characters waiting
   always @(posedge clk)
   begin
      if (txc_valid && txc_ready)
         seen.push_back(txc_data);
      txc_ready <= 1'($random(seed));
   end
   // Idle line shows the inverse so stale data never looks valid
   task send(input logic [7:0] c);
      rxc_valid <= 1'b1;
      rxc_data  <= c;
      @(posedge clk);
      rxc_valid <= 1'b0;
      rxc_data  <= ~c;
      @(posedge clk);
   endtask
endmodule

// ### tb/framer_props.sv
`timescale 1ns/1ps
module framer_props
   import framer_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic [7:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   input  wire logic [31:0] RDATA,
   input  wire logic        RXC_VALID,
   input  wire logic [7:0]  RXC_DATA,
   input  wire logic        RXF_VALID,
   input  wire logic        RXF_LAST,
   input  wire logic        TXP_READY,
   input  wire logic        TXC_VALID,
   input  wire logic [7:0]  TXC_DATA,
   input  wire logic        TXC_READY
);
   // ==========================================
   // Shadow of the character, length and timeout settings
   // ==========================================
   cfg_type cfg_ff;
   cfg_type nxt_cfg;
   wire logic [7:0] c8 = WDATA[7:0];
   assign nxt_cfg.start_chr  = ADDR == ADDR_START ? c8 : cfg_ff.start_chr;
   assign nxt_cfg.end1_chr   = ADDR == ADDR_END1 ? c8 : cfg_ff.end1_chr;
   assign nxt_cfg.end2_chr   = ADDR == ADDR_END2 ? c8 : cfg_ff.end2_chr;
   assign nxt_cfg.len_limit  = ADDR == ADDR_LEN ? WDATA[15:0] : cfg_ff.len_limit;
   assign nxt_cfg.timeout_ms = ADDR == ADDR_TIMEOUT ? WDATA[15:0] : cfg_ff.timeout_ms;
   always_ff @(posedge SYS_CLK)
   begin
      if (RST)
         cfg_ff <= '0;
      else if (WR)
         cfg_ff <= nxt_cfg;
   end
   wire logic hit_st = RXC_VALID && cfg_ff.start_chr != 8'h00 && RXC_DATA == cfg_ff.start_chr;
   wire logic hit_e1 = RXC_VALID && cfg_ff.end1_chr != 8'h00 && RXC_DATA == cfg_ff.end1_chr;
   wire logic hit_e2 = RXC_VALID && cfg_ff.end2_chr != 8'h00 && RXC_DATA == cfg_ff.end2_chr;
   wire logic plain  = RXC_VALID && RXC_DATA != cfg_ff.end1_chr && RXC_DATA != cfg_ff.end2_chr;

   // ==========================================
   // Properties
   // ==========================================
   default clocking dc @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   a_rxf_cause: assert property (RXF_VALID |-> $past(RXC_VALID))
      else $error("payload output without a received character");
   a_start_dropped: assert property (hit_st |=> !RXF_VALID)
      else $error("start character forwarded");
   a_open_any: assert property (RXC_VALID && cfg_ff.start_chr == 8'h00 |=> RXF_VALID)
      else $error("character dropped without start character");
   a_end1_last: assert property (hit_e1 |=> !RXF_VALID || RXF_LAST)
      else $error("first end character did not close frame");
   a_end2_last: assert property (hit_e2 |=> !RXF_VALID || RXF_LAST)
      else $error("second end character did not close frame");
   a_plain_mid: assert property (plain && cfg_ff.len_limit == 16'h0000 |=> !RXF_LAST)
      else $error("frame closed on a plain character");
   a_tx_hold: assert property (TXC_VALID && !TXC_READY |=> TXC_VALID && $stable(TXC_DATA))
      else $error("outgoing character changed before taken");
   a_txp_gap: assert property (TXP_READY |=> !TXP_READY)
      else $error("payload ready on two cycles in a row");
   a_ready_slot: assert property (TXP_READY |-> !TXC_VALID)
      else $error("payload ready while outgoing slot is occupied");
endmodule

bind ascii_serial_framer framer_props u_props
(
   .SYS_CLK   (SYS_CLK),
   .RST       (RST),
   .ADDR      (ADDR),
   .WDATA     (WDATA),
   .WR        (WR),
   .RD        (RD),
   .RDATA     (RDATA),
   .RXC_VALID (RXC_VALID),
   .RXC_DATA  (RXC_DATA),
   .RXF_VALID (RXF_VALID),
   .RXF_LAST  (RXF_LAST),
   .TXP_READY (TXP_READY),
   .TXC_VALID (TXC_VALID),
   .TXC_DATA  (TXC_DATA),
   .TXC_READY (TXC_READY)
);

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import framer_pkg::*;
   localparam int CPM = 10;
   logic        sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
   logic        txp_valid = 1'b0, txp_last = 1'b0;
   logic [7:0]  addr = 8'h00, txp_data = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        irq, rxc_valid, rxf_valid, rxf_first, rxf_last, txp_ready, txc_valid, txc_ready;
   logic [7:0]  rxc_data, rxf_data, txc_data;
   logic [31:0] rdata;
   integer      seed = 32'h0bac_9e30;
   int          error_cnt = 0;
   int          cmp_count = 0;
   logic [9:0]  got[$];
   logic [7:0]  exp_q[$];

   always #25 sys_clk = ~sys_clk;

   ascii_serial_framer #(.CYCLES_PER_MS(CPM)) uut
   (
      .SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .IRQ(irq), .RXC_VALID(rxc_valid), .RXC_DATA(rxc_data),
      .RXF_VALID(rxf_valid), .RXF_DATA(rxf_data), .RXF_FIRST(rxf_first), .RXF_LAST(rxf_last),
      .TXP_VALID(txp_valid), .TXP_DATA(txp_data), .TXP_LAST(txp_last), .TXP_READY(txp_ready),
      .TXC_VALID(txc_valid), .TXC_DATA(txc_data), .TXC_READY(txc_ready)
   );
   char_link_model link
   (
      .clk(sys_clk), .rxc_valid(rxc_valid), .rxc_data(rxc_data),
      .txc_valid(txc_valid), .txc_data(txc_data), .txc_ready(txc_ready)
   );

   always @(posedge sys_clk)
      if (rxf_valid)
         got.push_back({rxf_first, rxf_last, rxf_data});

   // ==========================================
   // Checking and bus tasks
   // ==========================================
   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
      @(posedge sys_clk);
   endtask
   task rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rd   <= 1'b1;
      addr <= a;
      @(posedge sys_clk);
      rd <= 1'b0;
      @(posedge sys_clk);
      chk(rdata & m, e);
   endtask
   function automatic logic [7:0] letter();
      letter = 8'h41 + 8'({$random(seed)} % 26);
   endfunction
   task set_cfg(input cfg_type c);
      wr_reg(ADDR_START, {24'h0, c.start_chr});
      wr_reg(ADDR_END1, {24'h0, c.end1_chr});
      wr_reg(ADDR_END2, {24'h0, c.end2_chr});
      wr_reg(ADDR_LEN, {16'h0, c.len_limit});
      wr_reg(ADDR_TIMEOUT, {16'h0, c.timeout_ms});
      rd_chk(ADDR_LEN, 32'hffff_ffff, {16'h0, c.len_limit});
   endtask

   // ==========================================
   // Receive and transmit scenarios
   // ==========================================
   task rx_case(input cfg_type c, input int n, input end_cause_type cause);
      logic [7:0] d;
      set_cfg(c);
      got.delete();
      exp_q.delete();
      if (c.start_chr != 8'h00)
      begin
         link.send(8'h23);
         link.send(c.start_chr);
      end
      for (int i = 0; i < n; i++)
      begin
         d = letter();
         exp_q.push_back(d);
         link.send(d);
         // Gaps shorter than the silence limit must not end the frame
         repeat (c.timeout_ms != 16'h0 ? 12 : 0) @(posedge sys_clk);
      end
      if (cause == END_CHR1 || cause == END_CHR2)
      begin
         d = cause == END_CHR1 ? c.end1_chr : c.end2_chr;
         exp_q.push_back(d);
         link.send(d);
      end
      repeat (CPM * c.timeout_ms + 8) @(posedge sys_clk);
      chk(got.size(), exp_q.size());
      foreach (exp_q[i])
         if (i < got.size())
            chk(got[i], {i == 0, cause != END_TIME && i == exp_q.size() - 1, exp_q[i]});
      rd_chk(ADDR_RX_STAT, 32'h0000_0007, cause);
      rd_chk(ADDR_RX_COUNT, 32'h0000_ffff, exp_q.size());
      rd_chk(ADDR_IRQ_STAT, 32'h0000_0007, {29'h0, c.start_chr != 8'h00, 2'b01});
      chk(irq, 1'b1);
      wr_reg(ADDR_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge sys_clk);
      chk(irq, 1'b0);
   endtask
   task tx_case(input cfg_type c, input int n);
      int k;
      set_cfg(c);
      link.seen.delete();
      exp_q.delete();
      if (c.start_chr != 8'h00)
         exp_q.push_back(c.start_chr);
      for (int i = 0; i < n; i++)
      begin
         exp_q.push_back(letter());
         txp_valid <= 1'b1;
         txp_data  <= exp_q[exp_q.size() - 1];
         txp_last  <= i == n - 1;
         k = 0;
         do
         begin
            @(posedge sys_clk);
            k++;
         end while (!txp_ready && k < 200);
         if (!txp_ready)
         begin
            error_cnt++;
            report_and_stop();
         end
      end
      txp_valid <= 1'b0;
      if (c.end1_chr != 8'h00)
         exp_q.push_back(c.end1_chr);
      if (c.end2_chr != 8'h00)
         exp_q.push_back(c.end2_chr);
      repeat (60) @(posedge sys_clk);
      chk(link.seen.size(), exp_q.size());
      foreach (exp_q[i])
         if (i < link.seen.size())
            chk(link.seen[i], exp_q[i]);
      chk(irq, 1'b0);
      rd_chk(ADDR_IRQ_STAT, 32'h0000_0007, 32'h0000_0002);
      wr_reg(ADDR_IRQ_STAT, 32'h0000_0007);
   endtask

   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      wr_reg(ADDR_RX_STAT, 32'hffff_ffff);
      wr_reg(ADDR_RX_COUNT, 32'hffff_ffff);
      wr_reg(8'h24, 32'hffff_ffff);
      for (int a = 0; a <= 36; a += 4)
         rd_chk(8'(a), 32'hffff_ffff, 32'h0000_0000);
      wr_reg(ADDR_IRQ_MASK, 32'h0000_0001);
      rx_case('{8'h00, 8'h0D, 8'h00, 16'h0, 16'h0}, 4, END_CHR1);
      rx_case('{8'h02, 8'h0D, 8'h0A, 16'h0, 16'h0}, 3, END_CHR2);
      rx_case('{8'h00, 8'h0D, 8'h00, 16'h5, 16'h0}, 5, END_LEN);
      rx_case('{8'h00, 8'h00, 8'h00, 16'h0, 16'h2}, 4, END_TIME);
      rx_case('{8'h00, 8'h0D, 8'h00, 16'h4, 16'h0}, 2, END_CHR1);
      rx_case('{8'h3A, 8'h0D, 8'h0A, 16'h0, 16'h2}, 3, END_CHR1);
      for (int r = 0; r < 4; r++)
         rx_case('{8'h00, 8'h0D, 8'h0A, 16'h0, 16'h0}, 1 + {$random(seed)} % 6,
                 r[0] ? END_CHR2 : END_CHR1);
      tx_case('{8'h00, 8'h0D, 8'h0A, 16'h0, 16'h0}, 3);
      tx_case('{8'h02, 8'h0D, 8'h00, 16'h0, 16'h0}, 1);
      tx_case('{8'h3A, 8'h00, 8'h0A, 16'h0, 16'h0}, 4);
      tx_case('{8'h00, 8'h00, 8'h00, 16'h0, 16'h0}, 2);
      report_and_stop();
   end
endmodule
